// [rtl/fr_watchdog_pkg.sv]
/*
  Shared constants for the free-running watchdog: register byte offsets,
  field positions, values after reset and comparison limits.
  Assumes a 32-bit register port with byte addresses on word boundaries.
*/
package fr_watchdog_pkg;

  // Address width of the register port.
  localparam int ADDR_W = 8;

  // Register byte offsets.
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_COUNTER = 8'h04;
  localparam logic [7:0] OFF_MATCH = 8'h08;
  localparam logic [7:0] OFF_INTR_STATUS = 8'h0C;
  localparam logic [7:0] OFF_INTR_MASK = 8'h10;
  localparam logic [7:0] OFF_OSC_CONFIG = 8'h14;
  localparam logic [7:0] OFF_CLK_SELECT = 8'h18;

  // Field positions.
  localparam int POS_RESET_EN = 0;
  localparam int POS_LOCK_LO = 30;
  localparam int POS_LOCK_HI = 31;
  localparam int POS_MATCH_LO = 0;
  localparam int POS_MATCH_HI = 15;
  localparam int POS_IGNORE_LO = 16;
  localparam int POS_IGNORE_HI = 19;
  localparam int POS_MATCH_FLAG = 0;
  localparam int POS_OSC_ENABLE = 31;
  localparam int POS_CLK_SEL_LO = 0;
  localparam int POS_CLK_SEL_HI = 1;

  // Lock field write codes.
  localparam logic [1:0] LOCK_CLR_BIT0 = 2'h1;
  localparam logic [1:0] LOCK_CLR_BIT1 = 2'h2;
  localparam logic [1:0] LOCK_SET_BOTH = 2'h3;

  // Values after reset.
  localparam logic [1:0] LOCK_RESET = 2'h3;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] MATCH_RESET = 16'h0000;
  localparam logic [3:0] IGNORE_RESET = 4'h0;
  localparam logic [31:0] OSC_CONFIG_RESET = 32'h8000_0000;
  localparam logic [1:0] CLK_SEL_RESET = 2'h0;
  localparam logic [1:0] MISSED_RESET = 2'h0;

  // Most upper counter bits that the comparison may ignore.
  localparam logic [3:0] IGNORE_MAX = 4'hC;
  // Unserviced match count at which the next match fires a reset.
  localparam logic [1:0] MISSED_LIMIT = 2'h2;

endpackage

// [rtl/free_running_watchdog.sv]
/*
  Free-running 16-bit watchdog with match interrupt, third-miss device
  reset and a two-step configuration lock, behind a plain register port.
  Assumes the oscillator and debug pins are asynchronous to clk, and that
  the wake strobe comes from same-clock power control logic.
*/
// Operation
// - Counter advances on oscillator edge when enabled
// - Match never clears counter; wraps naturally
// - Equal compared bits raise match event
// - Every equality, every pass, raises match
// - Match sets flag; write one clears
// - Third unserviced match fires device reset
// - Ignore field removes upper compared bits
// - Ignore above twelve acts as twelve
// - Ignoring bits leaves full counter intact
// - Enable bit gates device reset
// - Lock codes: none, clear0, clear1, set
// - One write locks; two unlock
// - Lock guards enable, match, osc, select
// - Lock engages on reset and wakeup
// - Mask bit forwards interrupt
// - Counter register reads present count
// - Servicing leaves counter value unchanged
// - Debug probe turns reset into interrupt
`timescale 1ns/1ps
module free_running_watchdog
  import fr_watchdog_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic osc_clk_pin,
  input wire logic debug_probe_pin,
  input wire logic lowpower_wake,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic match_irq,
  output logic device_reset,
  output logic osc_enable,
  output logic [1:0] low_freq_clock_select
);

  // Synchronised oscillator and debug probe pins.
  pin_sync_if osc_sync ();
  pin_sync_if dbg_sync ();

  // Configuration and state registers.
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] match_val_reg;
  logic [3:0] ignore_reg;
  logic reset_en_reg;
  logic [1:0] lock_reg;
  logic [31:0] osc_cfg_reg;
  logic [1:0] clk_sel_reg;
  logic match_flag_reg;
  logic mask_reg;
  logic [1:0] missed_reg;
  logic dbg_force_reg;
  logic device_reset_reg;
  logic [31:0] rdata_reg;
  // Decoded strobes and comparison terms.
  logic locked;
  logic advance;
  logic match_evt;
  logic service;
  logic [CNT_W-1:0] cmp_mask;
  logic fire;

  // Write decode used by every register write process.
  function automatic logic wr_hit(input logic [ADDR_W-1:0] off);
    wr_hit = reg_wr && (reg_addr == off);
  endfunction

  // Catch oscillator rising edges.
  pin_sync osc_pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .pin_in(osc_clk_pin),
    .sync(osc_sync.src)
  );

  // Follow the debug probe presence level.
  pin_sync dbg_pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .pin_in(debug_probe_pin),
    .sync(dbg_sync.src)
  );

  // The lock is engaged whenever either lock bit is set.
  assign locked = |lock_reg;

  // The count only moves while the oscillator is enabled and ticking.
  assign advance = osc_sync.rise && osc_cfg_reg[POS_OSC_ENABLE];
  assign count_next = count_reg + 1'b1;

  // Build the compare mask; large ignore settings saturate at the cap.
  always_comb begin
    logic [3:0] n;
    n = (ignore_reg > IGNORE_MAX) ? IGNORE_MAX : ignore_reg;
    cmp_mask = {CNT_W{1'b1}} >> n;
  end

  // A match is judged on the value the count is stepping to, so each pass
  // through the compare window gives exactly one event.
  assign match_evt = advance &&
    (((count_next ^ match_val_reg) & cmp_mask) == '0);

  // Software services the watchdog by writing one to the match flag.
  assign service = wr_hit(OFF_INTR_STATUS) && reg_wdata[POS_MATCH_FLAG];

  // The third match without service asks for a device reset.
  assign fire = match_evt && (missed_reg == MISSED_LIMIT) && reset_en_reg;

  // Free-running counter; a match never clears it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_reg <= COUNTER_RESET;
    end else if (ce && advance) begin
      // Wraps from all ones to zero by plain overflow.
      count_reg <= count_next;
    end
  end

  // Lock field. Decisions use the lock state before this write, so one
  // write cannot both unlock and change a guarded bit.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_reg <= LOCK_RESET;
    end else if (ce) begin
      if (lowpower_wake) begin
        // State is not kept over deep sleep, so it comes back locked.
        lock_reg <= LOCK_RESET;
      end else if (wr_hit(OFF_CONTROL)) begin
        case (reg_wdata[POS_LOCK_HI:POS_LOCK_LO])
          LOCK_CLR_BIT0: begin
            lock_reg[0] <= 1'b0;
          end
          LOCK_CLR_BIT1: begin
            lock_reg[1] <= 1'b0;
          end
          LOCK_SET_BOTH: begin
            lock_reg <= LOCK_SET_BOTH;
          end
          default: begin
            // Code zero leaves the lock alone.
            lock_reg <= lock_reg;
          end
        endcase
      end
    end
  end

  // Guarded configuration; writes under lock are dropped without a trace.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_en_reg <= 1'b0;
      match_val_reg <= MATCH_RESET;
      ignore_reg <= IGNORE_RESET;
      osc_cfg_reg <= OSC_CONFIG_RESET;
      clk_sel_reg <= CLK_SEL_RESET;
    end else if (ce && !locked) begin
      if (wr_hit(OFF_CONTROL)) begin
        reset_en_reg <= reg_wdata[POS_RESET_EN];
      end
      if (wr_hit(OFF_MATCH)) begin
        match_val_reg <= reg_wdata[POS_MATCH_HI:POS_MATCH_LO];
        ignore_reg <= reg_wdata[POS_IGNORE_HI:POS_IGNORE_LO];
      end
      if (wr_hit(OFF_OSC_CONFIG)) begin
        osc_cfg_reg <= reg_wdata;
      end
      if (wr_hit(OFF_CLK_SELECT)) begin
        clk_sel_reg <= reg_wdata[POS_CLK_SEL_HI:POS_CLK_SEL_LO];
      end
    end
  end

  // Interrupt mask is never guarded by the lock.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_reg <= 1'b0;
    end else if (ce && wr_hit(OFF_INTR_MASK)) begin
      mask_reg <= reg_wdata[POS_MATCH_FLAG];
    end
  end

  // Match flag. A match in the same cycle as a service write wins, so
  // the event is not lost.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      match_flag_reg <= 1'b0;
    end else if (ce) begin
      if (match_evt) begin
        match_flag_reg <= 1'b1;
      end else if (service) begin
        match_flag_reg <= 1'b0;
      end
    end
  end

  // Count of matches since the last service. A simultaneous match and
  // service leaves one fresh match on the books.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      missed_reg <= MISSED_RESET;
    end else if (ce) begin
      if (match_evt && service) begin
        missed_reg <= 2'h1;
      end else if (service) begin
        missed_reg <= MISSED_RESET;
      end else if (match_evt && missed_reg != MISSED_LIMIT) begin
        missed_reg <= missed_reg + 2'h1;
      end
    end
  end

  // Reset request, or with a probe present a forced interrupt instead.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      device_reset_reg <= 1'b0;
      dbg_force_reg <= 1'b0;
    end else if (ce) begin
      device_reset_reg <= fire && !dbg_sync.level;
      if (fire && dbg_sync.level) begin
        dbg_force_reg <= 1'b1;
      end else if (service) begin
        dbg_force_reg <= 1'b0;
      end
    end
  end

  // Read data stand only in the cycle after the read strobe. Unmapped
  // offsets and reserved bits read as zero.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      rdata_reg <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          OFF_CONTROL: begin
            rdata_reg[POS_LOCK_HI:POS_LOCK_LO] <= lock_reg;
            rdata_reg[POS_RESET_EN] <= reset_en_reg;
          end
          OFF_COUNTER: begin
            rdata_reg[CNT_W-1:0] <= count_reg;
          end
          OFF_MATCH: begin
            rdata_reg[POS_IGNORE_HI:POS_IGNORE_LO] <= ignore_reg;
            rdata_reg[POS_MATCH_HI:POS_MATCH_LO] <= match_val_reg;
          end
          OFF_INTR_STATUS: begin
            rdata_reg[POS_MATCH_FLAG] <= match_flag_reg;
          end
          OFF_INTR_MASK: begin
            rdata_reg[POS_MATCH_FLAG] <= mask_reg;
          end
          OFF_OSC_CONFIG: begin
            rdata_reg <= osc_cfg_reg;
          end
          OFF_CLK_SELECT: begin
            rdata_reg[POS_CLK_SEL_HI:POS_CLK_SEL_LO] <= clk_sel_reg;
          end
          default: begin
            rdata_reg <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Outputs. The interrupt is a gated level, not a pulse.
  assign reg_rdata = rdata_reg;
  assign match_irq = match_flag_reg && (mask_reg || dbg_force_reg);
  assign device_reset = device_reset_reg;
  assign osc_enable = osc_cfg_reg[POS_OSC_ENABLE];
  assign low_freq_clock_select = clk_sel_reg;

  // Checks on the watchdog behaviour.
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  lock_reset_a: assert property (
    $past(sys_rst) |-> lock_reg == LOCK_RESET
  ) else $error("lock not engaged after reset");

  count_step_a: assert property (
    ce && advance |=> count_reg == $past(count_reg) + 16'h0001
  ) else $error("counter did not step on oscillator edge");

  count_wrap_a: assert property (
    ce && advance && count_reg == 16'hFFFF |=> count_reg == 16'h0000
  ) else $error("counter did not wrap to zero");

  ignore_cap_a: assert property (
    ignore_reg > 4'hC |-> cmp_mask == 16'h000F
  ) else $error("ignore setting above cap not saturated");

  flag_set_a: assert property (
    ce && match_evt |=> match_flag_reg
  ) else $error("match did not set flag");

  flag_clear_a: assert property (
    ce && service && !match_evt |=> !match_flag_reg && missed_reg == 2'h0
  ) else $error("service did not clear flag and tracking");

  third_reset_a: assert property (
    ce && match_evt && missed_reg == 2'h2 && reset_en_reg &&
    !dbg_sync.level |=> device_reset
  ) else $error("third unserviced match gave no reset");

  reset_gate_a: assert property (
    device_reset |-> $past(reset_en_reg) && !$past(dbg_sync.level)
  ) else $error("reset fired while disabled or probe present");

  locked_write_a: assert property (
    ce && locked && reg_wr |=> $stable(match_val_reg) &&
    $stable(reset_en_reg)
  ) else $error("guarded state changed while locked");

  irq_mask_a: assert property (
    !mask_reg && !dbg_force_reg |-> !match_irq
  ) else $error("masked interrupt reached output");

  count_read_a: assert property (
    ce && reg_rd && reg_addr == OFF_COUNTER |=>
    reg_rdata[15:0] == $past(count_reg)
  ) else $error("counter read returned wrong value");

  match_seen_c: cover property (ce && match_evt);
  reset_fired_c: cover property (device_reset);
  unlock_seen_c: cover property (ce && lock_reg == 2'h0);
  debug_force_c: cover property (dbg_force_reg && match_irq);

endmodule

// [rtl/pin_sync.sv]
/*
  Three-stage synchroniser with agreement filter for one pin.
  Assumes the pin is asynchronous to clk and slower than clk / 4, so each level holds for two samples.
*/
`timescale 1ns/1ps
module pin_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic pin_in,
  pin_sync_if.src sync
);

  // Synchroniser stages; stage one is read only by stage two.
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  // Accepted level and rise pulse.
  logic level_reg;
  logic rise_reg;

  // Shift the pin through three flops.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else if (ce) begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts only once stages two and three agree, which filters
  // out a single metastable sample.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else if (ce) begin
      rise_reg <= 1'b0;
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
        rise_reg <= s3_reg & ~level_reg;
      end
    end
  end

  assign sync.level = level_reg;
  assign sync.rise = rise_reg;

endmodule

// [rtl/pin_sync_if.sv]
/*
  Carrier for a synchronised pin: the settled level and a one-cycle pulse
  on each rising change. Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
interface pin_sync_if;
  // Settled level of the pin.
  logic level;
  // One-cycle pulse when the settled level rises.
  logic rise;
  // Driving end.
  modport src (output level, output rise);
  // Consuming end.
  modport dst (input level, input rise);
endinterface

// [verif/free_running_watchdog_tb.sv]
/*
  Self-checking bench for the free-running watchdog: reset values, lock
  codes, counting, match flag, mask, third-miss reset and probe override.
  Assumes the register port answers reads one cycle after the strobe.
*/
`timescale 1ns/1ps
module free_running_watchdog_tb
  import fr_watchdog_pkg::*;
;
  logic clk, sys_rst, ce, osc_clk_pin, debug_probe_pin, lowpower_wake;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, match_irq, device_reset, osc_enable;
  logic [1:0] low_freq_clock_select;
  int errors = 0;
  int checks = 0;
  int resets = 0; // Device reset pulses seen.
  logic [15:0] cnt = 16'h0000; // Expected counter value.

  free_running_watchdog uut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .osc_clk_pin(osc_clk_pin), .debug_probe_pin(debug_probe_pin),
    .lowpower_wake(lowpower_wake), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .match_irq(match_irq),
    .device_reset(device_reset), .osc_enable(osc_enable),
    .low_freq_clock_select(low_freq_clock_select));

  // The clock toggles every 5 ns.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Reset pulses are counted here, since each stands a single cycle.
  always @(posedge clk) begin
    if (device_reset === 1'b1) begin
      resets++;
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One compare for every register or pin value.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Data is taken in the one cycle after the read edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Each tick holds the pin 5 cycles high and 5 low, above the filter.
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      osc_clk_pin <= 1'b1;
      repeat (5) @(posedge clk);
      osc_clk_pin <= 1'b0;
      repeat (5) @(posedge clk);
      cnt++;
    end
  endtask

  task automatic lock_code(input logic [1:0] c);
    wr(OFF_CONTROL, {c, 30'h0});
  endtask

  task automatic test_reset();
    rd(OFF_MATCH, d); chk(d, 32'h0);
    rd(OFF_CONTROL, d); chk(d, 32'hC000_0000);
    rd(OFF_COUNTER, d); chk(d, 32'h0);
    rd(OFF_OSC_CONFIG, d); chk(d, OSC_CONFIG_RESET);
    rd(8'h20, d); chk(d, 32'h0);
    chk({31'h0, osc_enable}, 32'h1);
    chk({31'h0, match_irq}, 32'h0);
    $display("test reset done");
  endtask

  task automatic test_lock();
    wr(OFF_MATCH, 32'h1234);
    rd(OFF_MATCH, d); chk(d, 32'h0);
    lock_code(LOCK_CLR_BIT0);
    wr(OFF_MATCH, 32'h1234);
    rd(OFF_MATCH, d); chk(d, 32'h0);
    lock_code(LOCK_CLR_BIT1);
    wr(OFF_MATCH, 32'h1234);
    rd(OFF_MATCH, d); chk(d, 32'h1234);
    wr(OFF_CLK_SELECT, 32'h2);
    lock_code(LOCK_SET_BOTH);
    lock_code(2'h0);
    wr(OFF_MATCH, 32'h0);
    wr(OFF_CLK_SELECT, 32'h1);
    wr(OFF_OSC_CONFIG, 32'h0);
    rd(OFF_MATCH, d); chk(d, 32'h1234);
    chk({30'h0, low_freq_clock_select}, 32'h2);
    chk({31'h0, osc_enable}, 32'h1);
    lock_code(LOCK_CLR_BIT0);
    lock_code(LOCK_CLR_BIT1);
    @(posedge clk);
    lowpower_wake <= 1'b1;
    @(posedge clk);
    lowpower_wake <= 1'b0;
    wr(OFF_MATCH, 32'h0);
    rd(OFF_MATCH, d); chk(d, 32'h1234);
    rd(OFF_CONTROL, d); chk(d, 32'hC000_0000);
    $display("test lock done");
  endtask

  task automatic test_count();
    lock_code(LOCK_CLR_BIT0);
    lock_code(LOCK_CLR_BIT1);
    wr(OFF_MATCH, 32'h0003);
    wr(OFF_INTR_STATUS, 32'h1);
    wr(OFF_INTR_MASK, 32'h1);
    ticks(2);
    rd(OFF_COUNTER, d); chk(d, {16'h0, cnt});
    rd(OFF_INTR_STATUS, d); chk(d[0], 1'b0);
    ticks(1);
    rd(OFF_INTR_STATUS, d); chk(d[0], 1'b1);
    chk({31'h0, match_irq}, 32'h1);
    wr(OFF_INTR_MASK, 32'h0);
    // The write lands on the edge that ends the task, so let it settle.
    #1;
    chk({31'h0, match_irq}, 32'h0);
    wr(OFF_INTR_STATUS, 32'h1);
    rd(OFF_INTR_STATUS, d); chk(d[0], 1'b0);
    rd(OFF_COUNTER, d); chk(d, 32'h3);
    $display("test count done");
  endtask

  // Ignore 15 acts as 12, so matches come every 16 ticks on low nibble 5.
  task automatic test_miss(input logic en, input logic probe);
    int k;
    int r0;
    wr(OFF_MATCH, 32'h000F_0005);
    wr(OFF_CONTROL, {31'h0, en});
    wr(OFF_INTR_STATUS, 32'h1);
    debug_probe_pin <= probe;
    k = (5 - cnt) & 15;
    if (k == 0) begin
      k = 16;
    end
    r0 = resets;
    ticks(k + 31);
    chk(resets, r0);
    rd(OFF_INTR_STATUS, d); chk(d[0], 1'b1);
    ticks(1);
    chk(resets, r0 + (en & !probe));
    chk({31'h0, match_irq}, {31'h0, probe & en});
    wr(OFF_INTR_STATUS, 32'h1);
    // The service lands on the edge that ends the task, so let it settle.
    #1;
    chk({31'h0, match_irq}, 32'h0);
    rd(OFF_COUNTER, d); chk(d, {16'h0, cnt});
    debug_probe_pin <= 1'b0;
    $display("test miss en %0d probe %0d done", en, probe);
  endtask

  // The longest run needs about 1600 cycles; this limit leaves room.
  initial begin
    #500000;
    errors++;
    finish_test();
  end

  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    osc_clk_pin = 1'b0;
    debug_probe_pin = 1'b0;
    lowpower_wake = 1'b0;
    reg_addr = '0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    test_reset();
    test_lock();
    test_count();
    test_miss(1'b0, 1'b0);
    test_miss(1'b1, 1'b0);
    test_miss(1'b1, 1'b1);
    finish_test();
  end
endmodule
